/* sfp_core.sv */
// Contract
// R1: opcode 7CH plus three address bytes wipes exactly one of 16 sectors.
// R2: host sends 528-mode 0a/0b wipe address as 2 pad, row 11..3, 13 pad.
// R3: host sends 528-mode sector 1-15 wipe as 2 pad, row 11..8, 18 pad.
// R4: host sends 512-mode wipe addresses with bits 20..12 or 20..17.
// R5: sector chosen from any row inside it; 0a, 0b, or row bits 11..8.
// R6: chip select rise after sector wipe starts timed erase, busy shown.
// R7: full-array wipe is C7H 94H 80H 9AH with no address bytes.
// R8: bytes after the full-wipe sequence are discarded.
// R9: chip select rise after full-wipe sequence starts timed erase, busy.
// R10: full wipe skips protected and locked sectors.
// R11: write-protect asserted mid-erase takes effect only after erase ends.
// R12: program via buffer is 82H or 85H, row bits and start offset.
// R13: host sends 512-mode program address as 3 pad, 12 row, 9 offset.
// R14: data bytes fill the buffer at rising offsets, wrapping to zero.
// R15: chip select rise erases the page, then programs it, busy throughout.
// R16: protection enabled state is shown on a status output.
// R17: 3DH 2AH 7FH A9H enables protection at chip select rise.
// R18: 3DH 2AH 7FH 9AH disables protection unless write-protect asserted.
// R19: write-protect pin idles deasserted; software alone then governs.
// R20: software protection is off after power-up reset.
// R21: write-protect enables protection; release lapses unless software set it.
// R22: sixteen-byte map, FFH marks a sector protected, 00H unprotected.
// R23: wipe or program of a protected sector is refused.
`default_nettype none
module sfp_core #(
   parameter int SECT_CYC = sfp_pkg::SFP_SECTOR_WIPE_CYC,
   parameter int FULL_CYC = sfp_pkg::SFP_FULL_WIPE_CYC,
   parameter int PROG_CYC = sfp_pkg::SFP_PROGRAM_CYC
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_si,
   input wire logic wp_n,
   input wire logic page_512,
   input wire logic [127:0] prot_map,
   input wire logic [16:0] lock_mask,
   input wire logic buf_rd_sel,
   input wire logic [9:0] buf_rd_addr,
   output logic [7:0] buf_rd_data,
   output logic rdy_busy_n,
   output logic stat_protect,
   output sfp_pkg::sfp_op_e array_op,
   output logic [16:0] wipe_mask,
   output logic [11:0] prog_row,
   output logic prog_buf,
   output logic refused
);
   import sfp_pkg::*;

   // link side, clocked by the host's serial clock
   logic [2:0] bit_cnt_q;
   logic [6:0] shf_q;
   logic [7:0] byte_hold_q;
   logic byte_tgl_q;
   wire [7:0] rx_byte_w = {shf_q, spi_si};

   // chip select ends the frame; the clock may stop right after
   always_ff @(posedge spi_sck or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         bit_cnt_q <= 3'h0;
         shf_q <= 7'h00;
      end else begin
         bit_cnt_q <= bit_cnt_q + 3'h1;
         shf_q <= rx_byte_w[6:0];
      end
   end

   // byte stays stable eight link clocks, far longer than the sync delay
   always_ff @(posedge spi_sck or posedge sys_rst) begin
      if (sys_rst) begin
         byte_hold_q <= 8'h00;
         byte_tgl_q <= 1'b0;
      end else if (!spi_cs_n && bit_cnt_q == 3'h7) begin
         byte_hold_q <= rx_byte_w;
         byte_tgl_q <= ~byte_tgl_q;
      end
   end

   // synchronisers into mclk
   logic tgl_s1_q, tgl_s2_q, tgl_s3_q;
   logic cs_s1_q, cs_s2_q, cs_s3_q, cs_s4_q;
   logic wp_s1_q, wp_s2_q, pg_s1_q, pg_s2_q;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         tgl_s1_q <= 1'b0;
         tgl_s2_q <= 1'b0;
         tgl_s3_q <= 1'b0;
         cs_s1_q <= SFP_PIN_IDLE;
         cs_s2_q <= SFP_PIN_IDLE;
         cs_s3_q <= SFP_PIN_IDLE;
         cs_s4_q <= SFP_PIN_IDLE;
         // R19: write-protect idles deasserted
         wp_s1_q <= SFP_PIN_IDLE;
         wp_s2_q <= SFP_PIN_IDLE;
         pg_s1_q <= 1'b0;
         pg_s2_q <= 1'b0;
      end else begin
         tgl_s1_q <= byte_tgl_q;
         tgl_s2_q <= tgl_s1_q;
         tgl_s3_q <= tgl_s2_q;
         cs_s1_q <= spi_cs_n;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
         cs_s4_q <= cs_s3_q;
         wp_s1_q <= wp_n;
         wp_s2_q <= wp_s1_q;
         pg_s1_q <= page_512;
         pg_s2_q <= pg_s1_q;
      end
   end

   // end is one stage later than the byte event so the last byte lands first
   wire byte_ev = tgl_s2_q ^ tgl_s3_q;
   wire frame_start = cs_s3_q & ~cs_s2_q;
   wire frame_end = cs_s3_q & ~cs_s4_q;

   // command decoder state
   logic [2:0] idx_q;
   logic [7:0] op_q;
   logic [23:0] addr_q;
   logic [9:0] ofs_q;
   logic live_q;
   sfp_op_e st_q, st_d;
   logic [31:0] cnt_q, cnt_d;
   logic sw_prot_q, wp_eff_q;
   logic [16:0] wipe_mask_q, wipe_mask_d;
   logic [11:0] prog_row_q;
   logic prog_buf_q, refused_q, rdy_busy_n_q, stat_protect_q;
   logic [7:0] buf_rd_data_q;
   logic [7:0] buf_mem [0:1][0:SFP_BUF_LEN-1];

   wire in_hdr = byte_ev && live_q && idx_q < SFP_HDR_BYTES;
   wire [23:0] addr_nx = {addr_q[15:0], byte_hold_q};
   wire is_prog = op_q == SFP_OP_PROG_B1 || op_q == SFP_OP_PROG_B2;
   wire hdr_done = idx_q == SFP_HDR_BYTES;
   // R14: data phase writes after the address bytes
   wire wr_ev = byte_ev && live_q && hdr_done && is_prog;
   wire [9:0] ofs_last = pg_s2_q ? SFP_OFS_LAST512 : SFP_OFS_LAST528;
   wire [9:0] hdr_ofs = pg_s2_q ? {1'b0, addr_nx[8:0]} : addr_nx[9:0];
   wire [9:0] ofs_nx = (ofs_q == ofs_last) ? 10'h000 : ofs_q + 10'h001;

   // frame bookkeeping; a frame opened while busy is ignored
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         idx_q <= 3'h0;
         op_q <= 8'h00;
         addr_q <= 24'h000000;
         ofs_q <= 10'h000;
         live_q <= 1'b0;
      end else if (frame_start) begin
         idx_q <= 3'h0;
         live_q <= st_q == SFP_IDLE;
      end else if (in_hdr) begin
         idx_q <= idx_q + 3'h1;
         if (idx_q == 3'h0) begin
            op_q <= byte_hold_q;
         end else begin
            // R8: bytes past the header never reach the address
            addr_q <= addr_nx;
         end
         if (idx_q == SFP_LAST_ADDR) begin
            ofs_q <= hdr_ofs;
         end
      end else if (wr_ev) begin
         // R14: wrap to offset zero after the last location
         ofs_q <= ofs_nx;
      end
   end

   always_ff @(posedge mclk) begin
      if (wr_ev) begin
         buf_mem[op_q == SFP_OP_PROG_B2][ofs_q] <= byte_hold_q;
      end
      buf_rd_data_q <= buf_mem[buf_rd_sel][buf_rd_addr];
   end

   // R12: row field position follows the page configuration
   wire [11:0] row = pg_s2_q ? addr_q[SFP_ROW512_LSB +: 12]
                             : addr_q[SFP_ROW528_LSB +: 12];
   wire [3:0] row_sect = row[11:SFP_SECT_LSB];
   wire [4:0] row_sub = row[SFP_SECT_LSB-1:SFP_SUB_LSB];
   // R5: target 0 is 0a, 1 is 0b, 2..16 are sectors 1..15
   wire [4:0] tgt_idx = (row_sect != 4'h0) ? {1'b0, row_sect} + 5'h01
                      : (row_sub == 5'h00) ? 5'h00 : 5'h01;
   wire [16:0] tgt_mask = 17'h00001 << tgt_idx;

   // R22: decode the protection map per target
   wire [16:0] prot_tgt;
   wire [7:0] map0 = prot_map[7:0];
   assign prot_tgt[0] = map0[SFP_P0A_LO +: 2] == SFP_PROT_PAIR;
   assign prot_tgt[1] = map0[SFP_P0B_LO +: 2] == SFP_PROT_PAIR;
   genvar g;
   generate
      for (g = 1; g < SFP_NSECT; g = g + 1) begin : g_map
         assign prot_tgt[g + 1] = prot_map[8*g +: 8] == SFP_PROT_MARK;
      end
   endgenerate

   // R21: pin or software turns protection on
   wire prot_en = sw_prot_q | wp_eff_q;
   wire [16:0] blk_mask = (prot_en ? prot_tgt : 17'h00000) | lock_mask;
   // R23: the target sector is refused when blocked
   wire tgt_blocked = |(tgt_mask & blk_mask);

   wire cmd_end = frame_end && live_q && hdr_done;
   wire prot_pfx = op_q == SFP_OP_PROT0
                   && addr_q[23:8] == {SFP_OP_PROT1, SFP_OP_PROT2};
   // R1: sector wipe command
   wire sect_cmd = cmd_end && op_q == SFP_OP_SECT_WIPE;
   // R7: four-byte full-wipe sequence
   wire full_go = cmd_end && op_q == SFP_OP_FULL0
                  && addr_q == {SFP_OP_FULL1, SFP_OP_FULL2, SFP_OP_FULL3};
   wire prog_cmd = cmd_end && is_prog;
   wire en_go = cmd_end && prot_pfx && addr_q[7:0] == SFP_OP_PROT_EN;
   wire dis_go = cmd_end && prot_pfx && addr_q[7:0] == SFP_OP_PROT_DIS;
   wire sect_go = sect_cmd && !tgt_blocked;
   wire prog_go = prog_cmd && !tgt_blocked;
   wire erasing = st_q == SFP_WIPE_SECT || st_q == SFP_WIPE_ALL
                  || st_q == SFP_PROG_ERASE;
   wire [31:0] prog_half = 32'(PROG_CYC / 2);

   always_comb begin
      st_d = st_q;
      cnt_d = (cnt_q != 32'h0) ? cnt_q - 32'h1 : cnt_q;
      wipe_mask_d = wipe_mask_q;
      case (st_q)
         SFP_IDLE: begin
            if (sect_go) begin
               // R6: self-timed sector erase
               st_d = SFP_WIPE_SECT;
               cnt_d = 32'(SECT_CYC - 1);
               wipe_mask_d = tgt_mask;
            end else if (full_go) begin
               // R9: self-timed full erase
               st_d = SFP_WIPE_ALL;
               cnt_d = 32'(FULL_CYC - 1);
               // R10: protected and locked sectors are left alone
               wipe_mask_d = ~blk_mask;
            end else if (prog_go) begin
               st_d = SFP_PROG_ERASE;
               cnt_d = prog_half - 32'h1;
               wipe_mask_d = 17'h00000;
            end
         end
         SFP_WIPE_SECT, SFP_WIPE_ALL: begin
            if (cnt_q == 32'h0) begin
               st_d = SFP_IDLE;
               wipe_mask_d = 17'h00000;
            end
         end
         SFP_PROG_ERASE: begin
            // R15: page erase first, then program
            if (cnt_q == 32'h0) begin
               st_d = SFP_PROG_WRITE;
               cnt_d = 32'(PROG_CYC) - prog_half - 32'h1;
            end
         end
         SFP_PROG_WRITE: begin
            if (cnt_q == 32'h0) begin
               st_d = SFP_IDLE;
            end
         end
         default: begin
            st_d = SFP_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_q <= SFP_IDLE;
         cnt_q <= 32'h0;
         wipe_mask_q <= 17'h00000;
         prog_row_q <= 12'h000;
         prog_buf_q <= 1'b0;
         refused_q <= 1'b0;
         rdy_busy_n_q <= 1'b1;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         wipe_mask_q <= wipe_mask_d;
         if (prog_go && st_q == SFP_IDLE) begin
            prog_row_q <= row;
            prog_buf_q <= op_q == SFP_OP_PROG_B2;
         end
         // R23: refusal pulse, nothing started
         refused_q <= (sect_cmd || prog_cmd) && tgt_blocked;
         // R6: busy pin low for the whole self-timed cycle
         rdy_busy_n_q <= st_d == SFP_IDLE;
      end
   end

   // protection state; power-up reset clears software protection
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         // R20: software protection off after reset
         sw_prot_q <= 1'b0;
         wp_eff_q <= 1'b0;
         stat_protect_q <= 1'b0;
      end else begin
         if (en_go) begin
            // R17: enable at chip select rise
            sw_prot_q <= 1'b1;
         end else if (dis_go && wp_s2_q) begin
            // R18: disable only while the pin is deasserted
            sw_prot_q <= 1'b0;
         end
         // R11: pin changes wait for the erase to finish
         if (!erasing) begin
            wp_eff_q <= ~wp_s2_q;
         end
         // R16: protection status output
         stat_protect_q <= prot_en;
      end
   end

   assign buf_rd_data = buf_rd_data_q;
   assign rdy_busy_n = rdy_busy_n_q;
   assign stat_protect = stat_protect_q;
   assign array_op = st_q;
   assign wipe_mask = wipe_mask_q;
   assign prog_row = prog_row_q;
   assign prog_buf = prog_buf_q;
   assign refused = refused_q;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   chk_busy_pin_state: assert property ( // R6
      $fell(rdy_busy_n_q) |-> $past(cmd_end))
      else $error("busy started without a command end");
   chk_sect_wipe_start: assert property ( // R5
      (st_q == SFP_IDLE && sect_go) |=>
         st_q == SFP_WIPE_SECT && wipe_mask_q == $past(tgt_mask))
      else $error("sector wipe did not start on its target");
   chk_full_skip_prot: assert property ( // R10
      (st_q == SFP_IDLE && full_go) |=>
         st_q == SFP_WIPE_ALL && (wipe_mask_q & $past(blk_mask)) == 17'h0)
      else $error("full wipe touches a protected sector");
   chk_wp_waits_erase: assert property ( // R11
      (erasing && !wp_eff_q) |=> !wp_eff_q)
      else $error("write-protect applied during erase");
   chk_wp_enables: assert property ( // R21
      (!erasing && !wp_s2_q) |=> ##1 stat_protect_q)
      else $error("asserted pin did not enable protection");
   chk_prot_enable: assert property ( // R17
      en_go |=> sw_prot_q ##1 stat_protect_q)
      else $error("enable sequence did not enable protection");
   chk_dis_ignored: assert property ( // R18
      (dis_go && !wp_s2_q && sw_prot_q) |=> sw_prot_q)
      else $error("disable accepted while pin asserted");
   chk_refuse_prot: assert property ( // R23
      ((sect_cmd || prog_cmd) && tgt_blocked && st_q == SFP_IDLE) |=>
         refused_q && st_q == SFP_IDLE && rdy_busy_n_q)
      else $error("protected target was not refused");
   chk_buf_wrap: assert property ( // R14
      (wr_ev && ofs_q == ofs_last) |=> ofs_q == 10'h000)
      else $error("buffer offset did not wrap");
   chk_prog_phases: assert property ( // R15
      (st_q == SFP_PROG_ERASE && cnt_q == 32'h0) |=>
         st_q == SFP_PROG_WRITE && !rdy_busy_n_q)
      else $error("program phase did not follow page erase");

   cov_sect_wipe: cover property (st_q == SFP_IDLE ##1 st_q == SFP_WIPE_SECT);
   cov_full_wipe: cover property (st_q == SFP_IDLE ##1 st_q == SFP_WIPE_ALL);
   cov_prog_done: cover property (st_q == SFP_PROG_WRITE ##1 st_q == SFP_IDLE);
   cov_refused: cover property (refused_q);
endmodule : sfp_core
`default_nettype wire

/* sfp_pkg.sv */
`default_nettype none
package sfp_pkg;
   // opcodes and command sequences
   localparam logic [7:0] SFP_OP_SECT_WIPE = 8'h7c;
   localparam logic [7:0] SFP_OP_FULL0 = 8'hc7;
   localparam logic [7:0] SFP_OP_FULL1 = 8'h94;
   localparam logic [7:0] SFP_OP_FULL2 = 8'h80;
   localparam logic [7:0] SFP_OP_FULL3 = 8'h9a;
   localparam logic [7:0] SFP_OP_PROG_B1 = 8'h82;
   localparam logic [7:0] SFP_OP_PROG_B2 = 8'h85;
   localparam logic [7:0] SFP_OP_PROT0 = 8'h3d;
   localparam logic [7:0] SFP_OP_PROT1 = 8'h2a;
   localparam logic [7:0] SFP_OP_PROT2 = 8'h7f;
   localparam logic [7:0] SFP_OP_PROT_EN = 8'ha9;
   localparam logic [7:0] SFP_OP_PROT_DIS = 8'h9a;
   // protection map
   localparam logic [7:0] SFP_PROT_MARK = 8'hff;
   localparam logic [1:0] SFP_PROT_PAIR = 2'h3;
   localparam int SFP_P0A_LO = 6;
   localparam int SFP_P0B_LO = 4;
   localparam int SFP_NSECT = 16;
   localparam int SFP_NTGT = 17;
   // frame layout: opcode plus three address bytes
   localparam logic [2:0] SFP_HDR_BYTES = 3'h4;
   localparam logic [2:0] SFP_LAST_ADDR = 3'h3;
   // address fields
   localparam int SFP_ROW528_LSB = 10;
   localparam int SFP_ROW512_LSB = 9;
   localparam int SFP_SECT_LSB = 8;
   localparam int SFP_SUB_LSB = 3;
   localparam int SFP_BUF_LEN = 528;
   localparam logic [9:0] SFP_OFS_LAST528 = 10'h20f;
   localparam logic [9:0] SFP_OFS_LAST512 = 10'h1ff;
   // self-timed cycles, times in microseconds
   localparam int SFP_CLK_MHZ = 100;
   localparam int SFP_SECTOR_WIPE_TIME_US = 5000;
   localparam int SFP_FULL_WIPE_TIME_US = 20000;
   localparam int SFP_PROGRAM_CYCLE_TIME_US = 4000;
   localparam int SFP_SECTOR_WIPE_CYC = SFP_SECTOR_WIPE_TIME_US * SFP_CLK_MHZ;
   localparam int SFP_FULL_WIPE_CYC = SFP_FULL_WIPE_TIME_US * SFP_CLK_MHZ;
   localparam int SFP_PROGRAM_CYC = SFP_PROGRAM_CYCLE_TIME_US * SFP_CLK_MHZ;
   // reset values
   localparam logic SFP_PIN_IDLE = 1'b1;
   typedef enum logic [4:0] {
      SFP_IDLE = 5'b00001,
      SFP_WIPE_SECT = 5'b00010,
      SFP_WIPE_ALL = 5'b00100,
      SFP_PROG_ERASE = 5'b01000,
      SFP_PROG_WRITE = 5'b10000
   } sfp_op_e;
endpackage : sfp_pkg
`default_nettype wire

/* sfp_host_model.sv */
`default_nettype none
module sfp_host_model (
   output logic spi_cs_n,
   output logic spi_sck,
   output logic spi_si
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      spi_cs_n = 1'b1;
      spi_sck = 1'b0;
      spi_si = 1'b0;
   end
   // whole bytes
   // msb first, framed by chip select; the clock stands low between frames
   task automatic send(input logic [7:0] b [0:7], input int n);
      int i;
      int k;
      // gap first, so the caller sees busy start after the return
      #107;
      spi_cs_n = 1'b0;
      for (i = 0; i < n; i++) begin
         for (k = 7; k >= 0; k--) begin
            spi_si = b[i][k];
            #15 spi_sck = 1'b1;
            #15 spi_sck = 1'b0;
         end
      end
      #15 spi_cs_n = 1'b1;
      // released line shows the inverse, never a stale value
      spi_si = ~spi_si;
   endtask : send
endmodule : sfp_host_model
`default_nettype wire

/* serial_flash_erase_program_protect_tb_top.sv */
`default_nettype none
module serial_flash_erase_program_protect_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import sfp_pkg::*;
   localparam int SC = 20;
   localparam int FC = 40;
   localparam int PC = 16;
   logic mclk, sys_rst, wp_n, page_512, buf_rd_sel;
   logic [127:0] prot_map;
   logic [16:0] lock_mask;
   logic [9:0] buf_rd_addr;
   logic [7:0] buf_rd_data;
   logic rdy_busy_n, stat_protect, prog_buf, refused;
   sfp_op_e array_op;
   logic [16:0] wipe_mask;
   logic [11:0] prog_row;
   wire spi_cs_n, spi_sck, spi_si;
   int miscompares = 0;
   int check_count = 0;
   int cyc = 0;
   int refusals = 0;
   int writes = 0;
   int i;
   localparam logic [12:0] TROW [0:4] = '{13'h0005, 13'h00f8, 13'h052a,
      13'h1f01, 13'h1008};
   localparam logic [16:0] TMSK [0:4] = '{17'h1, 17'h2, 17'h40, 17'h10000,
      17'h2};

   sfp_host_model host (.spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
      .spi_si(spi_si));
   sfp_core #(.SECT_CYC(SC), .FULL_CYC(FC), .PROG_CYC(PC)) dut (
      .mclk(mclk), .sys_rst(sys_rst), .spi_sck(spi_sck),
      .spi_cs_n(spi_cs_n), .spi_si(spi_si), .wp_n(wp_n),
      .page_512(page_512), .prot_map(prot_map), .lock_mask(lock_mask),
      .buf_rd_sel(buf_rd_sel), .buf_rd_addr(buf_rd_addr),
      .buf_rd_data(buf_rd_data), .rdy_busy_n(rdy_busy_n),
      .stat_protect(stat_protect), .array_op(array_op),
      .wipe_mask(wipe_mask), .prog_row(prog_row), .prog_buf(prog_buf),
      .refused(refused));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // sample away from the launching edge so the pulse is settled
   always @(negedge mclk) begin
      cyc <= cyc + 1;
      if (refused === 1'b1) refusals <= refusals + 1;
      if (array_op === SFP_PROG_WRITE) writes <= writes + 1;
      // hang guard, far above the expected run length
      if (cyc == 30000) begin
         miscompares++;
         complete_run();
      end
   end

   task automatic complete_run;
      if (miscompares == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // address bytes: pad, row, then offset or ignored bits
   function automatic logic [23:0] adr(input logic p5,
      input logic [11:0] row, input logic [9:0] ofs);
      adr = p5 ? {3'h0, row, ofs[8:0]} : {2'h0, row, ofs};
   endfunction : adr

   task automatic frame(input logic [7:0] op, input logic [23:0] a,
      input int n, input logic [7:0] d0, input logic [7:0] d1,
      input logic [7:0] d2);
      logic [7:0] fr [0:7];
      fr = '{op, a[23:16], a[15:8], a[7:0], d0, d1, d2, 8'h00};
      host.send(fr, n);
   endtask : frame

   task automatic prot(input logic [7:0] last);
      frame(SFP_OP_PROT0, {SFP_OP_PROT1, SFP_OP_PROT2, last}, 4, 8'h00,
         8'h00, 8'h00);
      repeat (10) @(negedge mclk);
   endtask : prot

   // waits for busy, checks targets and state, times the busy span;
   // wpm pulls write-protect low mid-erase and watches the status
   task automatic run_op(input logic [16:0] m, input int len,
      input sfp_op_e op, input logic wpm);
      int n;
      int bad;
      n = 0;
      bad = 0;
      while (rdy_busy_n !== 1'b0 && n < 20) begin
         @(negedge mclk);
         n++;
      end
      chk(32'(wipe_mask), 32'(m));
      chk(32'(array_op), 32'(op));
      n = 0;
      while (rdy_busy_n === 1'b0 && n < 3000) begin
         if (wpm) wp_n = 1'b0;
         if (wpm && stat_protect !== 1'b0) bad++;
         @(negedge mclk);
         n++;
      end
      chk(32'(n >= len && n <= len + 1), 32'h1);
      chk(32'(bad), 32'h0);
   endtask : run_op

   task automatic rd(input logic s, input logic [9:0] a, input logic [7:0] e);
      buf_rd_sel = s;
      buf_rd_addr = a;
      @(negedge mclk);
      @(negedge mclk);
      chk(32'(buf_rd_data), 32'(e));
   endtask : rd

   initial begin
      sys_rst = 1'b1;
      // pull-up: an undriven pin reads high
      wp_n = 1'b1;
      page_512 = 1'b0;
      prot_map = '0;
      lock_mask = '0;
      buf_rd_sel = 1'b0;
      buf_rd_addr = 10'h000;
      repeat (12) @(negedge mclk);
      sys_rst = 1'b0;
      chk(32'(rdy_busy_n), 32'h1);
      chk(32'(stat_protect), 32'h0);
      repeat (4) @(negedge mclk);
      for (i = 0; i < 5; i++) begin
         page_512 = TROW[i][12];
         repeat (4) @(negedge mclk);
         frame(SFP_OP_SECT_WIPE, adr(TROW[i][12], TROW[i][11:0], 10'h155),
            4, 8'h00, 8'h00, 8'h00);
         run_op(TMSK[i], SC, SFP_WIPE_SECT, 1'b0);
      end
      page_512 = 1'b0;
      lock_mask = 17'h20;
      frame(SFP_OP_FULL0, {SFP_OP_FULL1, SFP_OP_FULL2, SFP_OP_FULL3}, 6,
         SFP_OP_SECT_WIPE, SFP_OP_PROG_B1, 8'h00);
      run_op(17'h1ffdf, FC, SFP_WIPE_ALL, 1'b1);
      repeat (8) @(negedge mclk);
      chk(32'(stat_protect), 32'h1);
      wp_n = 1'b1;
      repeat (8) @(negedge mclk);
      chk(32'(stat_protect), 32'h0);
      prot(SFP_OP_PROT_EN);
      chk(32'(stat_protect), 32'h1);
      wp_n = 1'b0;
      prot(SFP_OP_PROT_DIS);
      chk(32'(stat_protect), 32'h1);
      wp_n = 1'b1;
      repeat (8) @(negedge mclk);
      chk(32'(stat_protect), 32'h1);
      prot_map[23:16] = SFP_PROT_MARK;
      frame(SFP_OP_SECT_WIPE, adr(1'b0, 12'h2c0, 10'h0), 4, 8'h00, 8'h00,
         8'h00);
      repeat (20) @(negedge mclk);
      chk(32'(refusals), 32'h1);
      chk(32'(rdy_busy_n), 32'h1);
      frame(SFP_OP_FULL0, {SFP_OP_FULL1, SFP_OP_FULL2, SFP_OP_FULL3}, 4,
         8'h00, 8'h00, 8'h00);
      run_op(17'h1ffd7, FC, SFP_WIPE_ALL, 1'b0);
      prot(SFP_OP_PROT_DIS);
      chk(32'(stat_protect), 32'h0);
      frame(SFP_OP_PROG_B1, adr(1'b0, 12'h123, 10'h20e), 7, 8'ha1, 8'hb2,
         8'hc3);
      run_op(17'h0, PC, SFP_PROG_ERASE, 1'b0);
      chk(32'(writes != 0), 32'h1);
      chk(32'(prog_row), 32'h123);
      chk(32'(prog_buf), 32'h0);
      rd(1'b0, 10'h20e, 8'ha1);
      rd(1'b0, 10'h20f, 8'hb2);
      rd(1'b0, 10'h000, 8'hc3);
      page_512 = 1'b1;
      // sector 4 stays locked otherwise and the program would be refused
      lock_mask = '0;
      repeat (4) @(negedge mclk);
      frame(SFP_OP_PROG_B2, adr(1'b1, 12'h456, 10'h1ff), 6, 8'h5a, 8'ha5,
         8'h00);
      run_op(17'h0, PC, SFP_PROG_ERASE, 1'b0);
      chk(32'(prog_row), 32'h456);
      chk(32'(prog_buf), 32'h1);
      rd(1'b1, 10'h1ff, 8'h5a);
      rd(1'b1, 10'h000, 8'ha5);
      complete_run();
   end
endmodule : serial_flash_erase_program_protect_tb_top
`default_nettype wire
